// ==== hw/ciu_pkg.sv ====
// Purpose: shared constants and types for the compare instruction unit
// Assumes: 32-bit instruction word, 32 general registers
// Notes: field positions follow the fixed instruction layout

package ciu_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int INSTR_W = 32;
  localparam int IDX_W = 5;
  localparam int IMM_W = 16;
  localparam int OP_W = 6;
  localparam int ZF_W = 5;

  // ----------------------------------------------------------------
  // instruction field positions
  // ----------------------------------------------------------------
  localparam int FA_HI = 31;
  localparam int FA_LO = 27;
  localparam int FB_HI = 26;
  localparam int FB_LO = 22;
  localparam int FC_HI = 21;
  localparam int FC_LO = 17;
  localparam int IMM_HI = 21;
  localparam int IMM_LO = 6;
  localparam int OPX_HI = 16;
  localparam int OPX_LO = 11;
  localparam int ZF_HI = 10;
  localparam int ZF_LO = 6;
  localparam int OP_HI = 5;
  localparam int OP_LO = 0;

  // ----------------------------------------------------------------
  // opcode values
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_LT_S_IMM = 6'h10;
  localparam logic [OP_W-1:0] OP_LT_U_IMM = 6'h30;
  localparam logic [OP_W-1:0] OP_NE_IMM = 6'h18;
  localparam logic [OP_W-1:0] OP_REG_FMT = 6'h3a;
  localparam logic [OP_W-1:0] OPX_LT_U = 6'h30;
  localparam logic [OP_W-1:0] OPX_NE = 6'h18;
  localparam logic [ZF_W-1:0] ZF_VALUE = 5'h00;

  // ----------------------------------------------------------------
  // constants for results and register zero
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] ZERO_REG = 5'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [IMM_W-1:0] IMM_HALF_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    CMP_NONE = 3'b000,
    CMP_LT_S_IMM = 3'b001,
    CMP_LT_U_IMM = 3'b010,
    CMP_LT_U_REG = 3'b011,
    CMP_NE_IMM = 3'b100,
    CMP_NE_REG = 3'b101
  } ciu_op_e;

endpackage

// ==== hw/ciu_reg_mem.sv ====
// Purpose: general register storage, one write and two read ports
// Assumes: reads are registered, one cycle after the address
// Notes: write-through so a read in the write cycle sees new data

`timescale 1ns/1ps

module ciu_reg_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddrA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB
);

  logic [WIDTH-1:0] store [DEPTH];

  // storage write
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // registered reads; bypass avoids stale data on a same-cycle write
  always_ff @(posedge clk) begin
    rdDataA <= (wrEn && wrAddr == rdAddrA) ? wrData : store[rdAddrA];
    rdDataB <= (wrEn && wrAddr == rdAddrB) ? wrData : store[rdAddrB];
  end

endmodule

// ==== hw/ciu_compare_unit.sv ====
// Purpose: decode and execute five integer compare instructions
// Assumes: one instruction offered per cycle with instrValid
// Notes: result written to the register store two edges after issue
//
// Contract
// - signed less-than against sign-extended immediate
// - unsigned less-than between two registers
// - unsigned less-than against zero-extended immediate
// - not-equal between two registers
// - not-equal against sign-extended immediate
// - primary opcodes 0x10, 0x30, 0x18 select immediates
// - register format extended opcodes 0x30, 0x18
// - immediate form: source A, destination B
// - register form: sources A, B, destination C

`timescale 1ns/1ps

module ciu_compare_unit #(
  parameter int REG_COUNT = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic instrValid,
  input wire logic [ciu_pkg::INSTR_W-1:0] instrWord,
  input wire logic extWrValid,
  input wire logic [ciu_pkg::IDX_W-1:0] extWrIdx,
  input wire logic [ciu_pkg::DATA_W-1:0] extWrData,
  output logic extWrReady,
  output logic resultValid,
  output logic [ciu_pkg::IDX_W-1:0] resultIdx,
  output logic [ciu_pkg::DATA_W-1:0] resultData,
  output logic unknownInstr
);

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  logic [ciu_pkg::IDX_W-1:0] fieldA;
  logic [ciu_pkg::IDX_W-1:0] fieldB;
  logic [ciu_pkg::IDX_W-1:0] fieldC;
  logic [ciu_pkg::IMM_W-1:0] immField;
  logic [ciu_pkg::OP_W-1:0] opField;
  logic [ciu_pkg::OP_W-1:0] opxField;
  logic [ciu_pkg::ZF_W-1:0] zeroField;
  ciu_pkg::ciu_op_e next_op;
  logic [ciu_pkg::IDX_W-1:0] next_dest;

  assign fieldA = instrWord[ciu_pkg::FA_HI:ciu_pkg::FA_LO];
  assign fieldB = instrWord[ciu_pkg::FB_HI:ciu_pkg::FB_LO];
  assign fieldC = instrWord[ciu_pkg::FC_HI:ciu_pkg::FC_LO];
  assign immField = instrWord[ciu_pkg::IMM_HI:ciu_pkg::IMM_LO];
  assign opField = instrWord[ciu_pkg::OP_HI:ciu_pkg::OP_LO];
  assign opxField = instrWord[ciu_pkg::OPX_HI:ciu_pkg::OPX_LO];
  assign zeroField = instrWord[ciu_pkg::ZF_HI:ciu_pkg::ZF_LO];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // non-compare words decode to none; other units handle them
  always_comb begin
    next_op = ciu_pkg::CMP_NONE;
    next_dest = fieldB;
    if (opField == ciu_pkg::OP_REG_FMT && zeroField == ciu_pkg::ZF_VALUE) begin
      next_dest = fieldC;
      if (opxField == ciu_pkg::OPX_LT_U) begin
        next_op = ciu_pkg::CMP_LT_U_REG;
      end else if (opxField == ciu_pkg::OPX_NE) begin
        next_op = ciu_pkg::CMP_NE_REG;
      end
    end else if (opField == ciu_pkg::OP_LT_S_IMM) begin
      next_op = ciu_pkg::CMP_LT_S_IMM;
    end else if (opField == ciu_pkg::OP_LT_U_IMM) begin
      next_op = ciu_pkg::CMP_LT_U_IMM;
    end else if (opField == ciu_pkg::OP_NE_IMM) begin
      next_op = ciu_pkg::CMP_NE_IMM;
    end
  end

  // ----------------------------------------------------------------
  // execute stage registers
  // ----------------------------------------------------------------
  logic s1Valid;
  ciu_pkg::ciu_op_e s1Op;
  logic [ciu_pkg::IDX_W-1:0] s1Dest;
  logic [ciu_pkg::IDX_W-1:0] s1IdxA;
  logic [ciu_pkg::IDX_W-1:0] s1IdxB;
  logic [ciu_pkg::IMM_W-1:0] s1Imm;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1Valid <= 1'b0;
      s1Op <= ciu_pkg::CMP_NONE;
      s1Dest <= ciu_pkg::ZERO_REG;
      s1IdxA <= ciu_pkg::ZERO_REG;
      s1IdxB <= ciu_pkg::ZERO_REG;
      s1Imm <= ciu_pkg::IMM_HALF_ZERO;
    end else begin
      s1Valid <= instrValid && next_op != ciu_pkg::CMP_NONE;
      s1Op <= next_op;
      s1Dest <= next_dest;
      s1IdxA <= fieldA;
      s1IdxB <= fieldB;
      s1Imm <= immField;
    end
  end

  // unrecognised word flag, one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      unknownInstr <= 1'b0;
    end else begin
      unknownInstr <= instrValid && next_op == ciu_pkg::CMP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // register store and operands
  // ----------------------------------------------------------------
  logic memWrEn;
  logic [ciu_pkg::IDX_W-1:0] memWrIdx;
  logic [ciu_pkg::DATA_W-1:0] memWrData;
  logic [ciu_pkg::DATA_W-1:0] rawA;
  logic [ciu_pkg::DATA_W-1:0] rawB;
  logic [ciu_pkg::DATA_W-1:0] opA;
  logic [ciu_pkg::DATA_W-1:0] opB;
  logic [ciu_pkg::DATA_W-1:0] immSx;
  logic [ciu_pkg::DATA_W-1:0] immZx;
  logic cmpBit;
  logic wbEn;

  ciu_reg_mem #(
    .WIDTH(ciu_pkg::DATA_W),
    .DEPTH(REG_COUNT),
    .AW(ciu_pkg::IDX_W)
  ) regStore (
    .clk(core_clk),
    .wrEn(memWrEn),
    .wrAddr(memWrIdx),
    .wrData(memWrData),
    .rdAddrA(fieldA),
    .rdAddrB(fieldB),
    .rdDataA(rawA),
    .rdDataB(rawB)
  );

  assign opA = (s1IdxA == ciu_pkg::ZERO_REG) ? ciu_pkg::DATA_ZERO : rawA;
  assign opB = (s1IdxB == ciu_pkg::ZERO_REG) ? ciu_pkg::DATA_ZERO : rawB;

  assign immSx = {{(ciu_pkg::DATA_W-ciu_pkg::IMM_W){s1Imm[ciu_pkg::IMM_W-1]}}, s1Imm};
  assign immZx = {ciu_pkg::IMM_HALF_ZERO, s1Imm};

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_comb begin
    cmpBit = 1'b0;
    unique case (s1Op)
      ciu_pkg::CMP_NONE: cmpBit = 1'b0;
      ciu_pkg::CMP_LT_S_IMM: cmpBit = $signed(opA) < $signed(immSx);
      ciu_pkg::CMP_LT_U_IMM: cmpBit = opA < immZx;
      ciu_pkg::CMP_LT_U_REG: cmpBit = opA < opB;
      ciu_pkg::CMP_NE_IMM: cmpBit = opA != immSx;
      ciu_pkg::CMP_NE_REG: cmpBit = opA != opB;
      default: cmpBit = 1'b0;
    endcase
  end

  assign wbEn = s1Valid && s1Dest != ciu_pkg::ZERO_REG;
  // outside writes yield to compare results; held off in every cycle that s1Valid is high
  assign extWrReady = !s1Valid;
  assign memWrEn = wbEn || (extWrValid && extWrReady && extWrIdx != ciu_pkg::ZERO_REG);
  assign memWrIdx = s1Valid ? s1Dest : extWrIdx;
  // single bit zero-extended to full width
  assign memWrData = s1Valid ? {{(ciu_pkg::DATA_W-1){1'b0}}, cmpBit} : extWrData;

  // result report, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      resultValid <= 1'b0;
      resultIdx <= ciu_pkg::ZERO_REG;
      resultData <= ciu_pkg::DATA_ZERO;
    end else begin
      resultValid <= s1Valid;
      resultIdx <= s1Dest;
      resultData <= {{(ciu_pkg::DATA_W-1){1'b0}}, cmpBit};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence immIssue;
    instrValid && (opField == ciu_pkg::OP_LT_S_IMM || opField == ciu_pkg::OP_LT_U_IMM
      || opField == ciu_pkg::OP_NE_IMM);
  endsequence
  sequence regIssue;
    instrValid && opField == ciu_pkg::OP_REG_FMT && zeroField == ciu_pkg::ZF_VALUE
      && (opxField == ciu_pkg::OPX_LT_U || opxField == ciu_pkg::OPX_NE);
  endsequence

  ltsImm_a: assert property (s1Valid && s1Op == ciu_pkg::CMP_LT_S_IMM |=>
    resultData[0] == $past($signed(opA) < $signed({{16{s1Imm[15]}}, s1Imm})))
    else $error("signed immediate compare wrong");
  ltuReg_a: assert property (s1Valid && s1Op == ciu_pkg::CMP_LT_U_REG |=>
    resultData[0] == $past(opA < opB))
    else $error("unsigned register compare wrong");
  ltuImm_a: assert property (s1Valid && s1Op == ciu_pkg::CMP_LT_U_IMM |=>
    resultData[0] == $past(opA < {16'h0000, s1Imm}))
    else $error("unsigned immediate compare wrong");
  neReg_a: assert property (s1Valid && s1Op == ciu_pkg::CMP_NE_REG |=>
    resultData[0] == $past(opA != opB))
    else $error("register not-equal wrong");
  neImm_a: assert property (s1Valid && s1Op == ciu_pkg::CMP_NE_IMM |=>
    resultData[0] == $past(opA != {{16{s1Imm[15]}}, s1Imm}))
    else $error("immediate not-equal wrong");
  primDecode_a: assert property (immIssue |=> s1Valid && !unknownInstr)
    else $error("immediate compare not decoded");
  extDecode_a: assert property (instrValid && opField == ciu_pkg::OP_REG_FMT
    && zeroField != ciu_pkg::ZF_VALUE |=> !s1Valid && unknownInstr)
    else $error("nonzero field accepted");
  immDest_a: assert property (immIssue |=> ##1 resultValid
    && resultIdx == $past(instrWord[ciu_pkg::FB_HI:ciu_pkg::FB_LO], 2))
    else $error("immediate destination wrong");
  regDest_a: assert property (regIssue |=> ##1 resultValid
    && resultIdx == $past(instrWord[ciu_pkg::FC_HI:ciu_pkg::FC_LO], 2)
    && resultData[ciu_pkg::DATA_W-1:1] == '0)
    else $error("register destination wrong");
  zeroDrop_a: assert property (s1Valid && s1Dest == ciu_pkg::ZERO_REG |-> !memWrEn)
    else $error("write to register zero");

endmodule

// ==== bench/ciu_loader.sv ====
// Purpose: far-side loader for the outside register write port
// Assumes: request held until ready is seen high at an edge
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module ciu_loader (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [4:0] idx,
  input wire logic [31:0] data,
  output logic done = 1'b0,
  output logic extWrValid = 1'b0,
  output logic [4:0] extWrIdx = 5'h00,
  output logic [31:0] extWrData = 32'h0000_0000,
  input wire logic extWrReady
);
  // ----------------------------------------
  // write handshake
  // ----------------------------------------
  // hold until the accepting edge; inverted idle lines so stale data never passes
  always_ff @(posedge core_clk) begin
    done <= extWrValid && extWrReady;
    if (srst || (extWrValid && extWrReady)) begin
      extWrValid <= 1'b0;
      extWrIdx <= ~extWrIdx;
      extWrData <= ~extWrData;
    end else if (go && !extWrValid) begin
      extWrValid <= 1'b1;
      extWrIdx <= idx;
      extWrData <= data;
    end
  end
endmodule

// ==== bench/compare_instruction_unit_tb.sv ====
// Purpose: self-checking bench for the compare unit
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes: expectations come from a shadow register model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module compare_instruction_unit_tb;
  typedef struct {int due; logic [4:0] idx; logic [31:0] data;} ciu_exp_s;
  logic core_clk = 1'b0, srst = 1'b1, instrValid = 1'b0, go = 1'b0;
  logic [31:0] instrWord = 32'h0000_0000, ldData = 32'h0000_0000, seed = 32'h0000_bb09;
  logic [4:0] ldIdx = 5'h00;
  logic extWrValid, extWrReady, resultValid, unknownInstr, done;
  logic [4:0] extWrIdx, resultIdx;
  logic [31:0] extWrData, resultData;
  logic [31:0] regs [32];
  ciu_exp_s resQ[$];
  int unkQ[$];
  int cyc = 0, n_fail = 0, n_compared = 0;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  // free-running core clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  ciu_compare_unit i_dut (.core_clk(core_clk), .srst(srst), .instrValid(instrValid),
    .instrWord(instrWord), .extWrValid(extWrValid), .extWrIdx(extWrIdx),
    .extWrData(extWrData), .extWrReady(extWrReady), .resultValid(resultValid),
    .resultIdx(resultIdx), .resultData(resultData), .unknownInstr(unknownInstr));
  ciu_loader i_load (.core_clk(core_clk), .srst(srst), .go(go), .idx(ldIdx),
    .data(ldData), .done(done), .extWrValid(extWrValid), .extWrIdx(extWrIdx),
    .extWrData(extWrData), .extWrReady(extWrReady));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] a, b,
      input logic [15:0] imm);
    return {a, b, imm, op};
  endfunction
  // offer one word and queue what must come out
  task automatic issue(input logic [31:0] w);
    logic [31:0] a, b, s;
    logic hit, r;
    logic [4:0] d;
    a = regs[w[31:27]];
    b = regs[w[26:22]];
    s = {{16{w[21]}}, w[21:6]};
    hit = 1'b1;
    d = w[26:22];
    r = 1'b0;
    case (w[5:0])
      6'h10: r = $signed(a) < $signed(s);
      6'h30: r = a < {16'h0000, w[21:6]};
      6'h18: r = a != s;
      6'h3a: begin
        d = w[21:17];
        hit = w[10:6] == 5'h00 && (w[16:11] == 6'h30 || w[16:11] == 6'h18);
        r = w[16:11] == 6'h30 ? a < b : a != b;
      end
      default: hit = 1'b0;
    endcase
    if (hit) begin
      resQ.push_back('{cyc + 3, d, {31'h0, r}});
      if (d != 5'h00) regs[d] = {31'h0, r};
    end else begin
      unkQ.push_back(cyc + 2);
    end
    instrValid <= 1'b1;
    instrWord <= w;
  endtask
  // outside write, bounded wait for acceptance
  task automatic load(input logic [4:0] i, input logic [31:0] v);
    int k;
    go <= 1'b1;
    ldIdx <= i;
    ldData <= v;
    @(posedge core_clk);
    go <= 1'b0;
    instrValid <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge core_clk);
    if (done !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    if (i != 5'h00) regs[i] = v;
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  // sample mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    cyc++;
    if (resQ.size() > 0 && resQ[0].due == cyc) begin
      `CHK("resultValid", 1'b1, resultValid)
      `CHK("resultIdx", resQ[0].idx, resultIdx)
      `CHK("resultData", resQ[0].data, resultData)
      void'(resQ.pop_front());
    end else begin
      `CHK("resultValid", 1'b0, resultValid)
    end
    `CHK("extWrReady", !(resQ.size() > 0 && resQ[0].due == cyc + 1), extWrReady)
    if (unkQ.size() > 0 && unkQ[0] == cyc) begin
      `CHK("unknownInstr", 1'b1, unknownInstr)
      void'(unkQ.pop_front());
    end else begin
      `CHK("unknownInstr", 1'b0, unknownInstr)
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  // corner operands first, then random traffic with stalls and gaps
  initial begin
    int i;
    logic [31:0] w;
    logic [4:0] a, b, c;
    logic [31:0] cv [8];
    cv = '{32'h1234_5678, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff,
      32'h0000_8000, 32'hffff_8000, 32'h0000_0000, 32'h0000_ffff};
    for (i = 0; i < 32; i++) regs[i] = 32'h0000_0000;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    // store is not reset: give every index a known value, random words may name any
    for (i = 0; i < 32; i++) load(i[4:0], cv[i[2:0]] ^ {i[4:3], i[4:3], 28'h000_0000});
    for (i = 0; i < 600; i++) begin
      seed = xs(seed);
      a = {2'b00, seed[2:0]};
      b = {2'b00, seed[5:3]};
      c = {2'b00, seed[8:6]};
      case (seed[11:9])
        3'd0: w = mk(6'h10, a, b, seed[19] ? {seed[20], 15'h7fff} : seed[31:16]);
        3'd1: w = mk(6'h30, a, b, seed[19] ? {seed[20], 15'h7fff} : seed[31:16]);
        3'd2: w = mk(6'h18, a, b, seed[19] ? regs[a][15:0] : seed[31:16]);
        3'd3: w = mk(6'h3a, a, b, {c, 6'h30, 5'h00});
        3'd4: w = mk(6'h3a, a, b, {c, 6'h18, 5'h00});
        3'd5: w = mk(6'h3a, a, b, {c, seed[17:12], seed[22:18]});
        3'd6: w = seed;
        default: w = mk(seed[17:12], a, b, seed[31:16]);
      endcase
      @(posedge core_clk);
      issue(w);
      if (seed[15:13] == 3'd0) begin
        load({2'b00, seed[27:25]}, xs(seed));
      end else if (seed[12]) begin
        @(posedge core_clk);
        instrValid <= 1'b0;
      end
    end
    @(posedge core_clk);
    instrValid <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK("pending", 0, resQ.size() + unkQ.size())
    report_and_stop();
  end
endmodule
